// >>> hw/ufpc_pkg.sv
// Constants shared by the user flash program controller.
// Assumes a single 40 MHz clock and a synchronous active-high reset.
package ufpc_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;          // 40 MHz bus clock
  localparam int PROG_TIME_NS = 1000;         // Program duration, plain default
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] PROG_LAST = 6'(PROG_CYCLES - 1);

  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int ADDR_W = 7;                  // Data port word address width
  localparam int WORDS = 64;                  // Words in the user flash array
  localparam logic [6:0] ADDR_LIMIT = 7'h40;  // First illegal word address
  localparam int SECT_LSB = 4;                // Sector select bits [5:4]
  localparam int SECTORS = 4;
  localparam logic [3:0] SECTOR_LOCK = 4'h0;  // Sector lock straps, all clear
  localparam logic [31:0] ERASED_WORD = 32'hffffffff;
  localparam logic [7:0] BURST_ONE = 8'h01;   // Required burst count, parallel

  // ----------------------------------------
  // Control port map
  // ----------------------------------------
  localparam logic CSR_STATUS = 1'b0;         // Status register offset
  localparam logic CSR_CONTROL = 1'b1;        // Control register offset 0x01
  localparam logic [31:0] CONTROL_RESET = 32'h0000000f;  // All sectors protected
  localparam int WP_LSB = 0;                  // Write-protect bits [3:0]
  localparam int ST_BUSY_LSB = 0;             // Busy field [1:0]
  localparam int ST_RSUCC = 2;                // Read success bit
  localparam int ST_WSUCC = 3;                // Write success bit

  // ----------------------------------------
  // Busy field codes
  // ----------------------------------------
  localparam logic [1:0] BUSY_IDLE = 2'h0;
  localparam logic [1:0] BUSY_PROG = 2'h2;

  typedef enum logic [0:0] {UFPC_IDLE, UFPC_PROG} ufpc_state_e;
endpackage

// >>> hw/ufpc_top.sv
// User flash program controller: control slave and data slave in one module.
// Assumes an Avalon-MM master on the same clock; control read latency is one.
`timescale 1ns/10ps

// Behaviour
// - Control read returns addressed register value
// - Control write to 0x01 stores value
// - Program one 32-bit word via data port
// - Busy field shows program code while programming
// - Good program completion sets write success
// - Bad burst, range or protection clears success
// - Busy field zero when idle
// - Control serves registers, data serves flash
module ufpc_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control slave
  input wire logic csr_address_i,
  input wire logic csr_read_i,
  input wire logic csr_write_i,
  input wire logic [31:0] csr_writedata_i,
  output logic [31:0] csr_readdata_o,
  // Data slave
  input wire logic [6:0] data_address_i,
  input wire logic data_read_i,
  input wire logic data_write_i,
  input wire logic [31:0] data_writedata_i,
  input wire logic [7:0] data_burstcount_i,
  output logic data_waitrequest_o,
  output logic data_readdatavalid_o,
  output logic [31:0] data_readdata_o
);
  // ----------------------------------------
  // State and storage
  // ----------------------------------------
  ufpc_pkg::ufpc_state_e state;               // Program sequencer
  logic [5:0] cnt;                            // Program cycles remaining
  logic [31:0] flash_control;                 // Control register
  logic [1:0] busy;                           // Status busy field
  logic rsucc;                                // Read success flag
  logic wsucc;                                // Write success flag
  logic [6:0] prog_addr;                      // Latched program address
  logic [31:0] prog_data;                     // Latched program word
  logic [31:0] user_flash_array [ufpc_pkg::WORDS];  // Flash contents

  // Address legality, used by both read and program paths
  function automatic logic in_range(input logic [6:0] a);
    in_range = a < ufpc_pkg::ADDR_LIMIT;
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic [1:0] sect = data_address_i[ufpc_pkg::SECT_LSB +: 2];
  wire logic [3:0] wp = flash_control[ufpc_pkg::WP_LSB +: ufpc_pkg::SECTORS];
  wire logic protect = wp[sect] | ufpc_pkg::SECTOR_LOCK[sect];
  wire logic legal = in_range(data_address_i);
  // Command taken only while waitrequest is low
  wire logic wr_take = data_write_i & ~data_waitrequest_o;
  wire logic rd_take = data_read_i & ~data_waitrequest_o;
  // Any failed check rejects the word without touching the array
  wire logic bad = (data_burstcount_i != ufpc_pkg::BURST_ONE) | ~legal | protect;
  wire logic good_take = wr_take & ~bad;
  wire logic bad_take = wr_take & bad;
  wire logic prog_done = (state == ufpc_pkg::UFPC_PROG) && (cnt == 6'h0);
  wire logic [31:0] status_word = {28'h0, wsucc, rsucc, busy};
  wire logic [31:0] csr_sel = (csr_address_i == ufpc_pkg::CSR_CONTROL) ? flash_control : status_word;
  wire logic [31:0] rd_word = legal ? user_flash_array[data_address_i[5:0]] : ufpc_pkg::ERASED_WORD;

  // ----------------------------------------
  // Control slave
  // ----------------------------------------
  // Register write and one-cycle read answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_control <= ufpc_pkg::CONTROL_RESET;
      csr_readdata_o <= 32'h0;
    end else begin
      // Only offset 0x01 is writable; status writes are dropped
      if (csr_write_i && csr_address_i == ufpc_pkg::CSR_CONTROL) begin
        flash_control <= csr_writedata_i;
      end
      // Stale value held when no read, so the bus sees no glitches
      if (csr_read_i) begin
        csr_readdata_o <= csr_sel;
      end
    end
  end

  // ----------------------------------------
  // Program sequencer
  // ----------------------------------------
  // Idle accepts one word; busy runs a fixed count then commits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ufpc_pkg::UFPC_IDLE;
      cnt <= 6'h0;
      busy <= ufpc_pkg::BUSY_IDLE;
      wsucc <= 1'b0;
      data_waitrequest_o <= 1'b0;
      prog_addr <= 7'h0;
      prog_data <= 32'h0;
    end else begin
      case (state)
        ufpc_pkg::UFPC_IDLE: begin
          // Every command judged on its own inputs
          if (good_take) begin
            state <= ufpc_pkg::UFPC_PROG;
            cnt <= ufpc_pkg::PROG_LAST;
            busy <= ufpc_pkg::BUSY_PROG;
            data_waitrequest_o <= 1'b1;
            prog_addr <= data_address_i;
            prog_data <= data_writedata_i;
          end else if (bad_take) begin
            wsucc <= 1'b0;
          end
        end
        ufpc_pkg::UFPC_PROG: begin
          if (prog_done) begin
            state <= ufpc_pkg::UFPC_IDLE;
            busy <= ufpc_pkg::BUSY_IDLE;
            wsucc <= 1'b1;
            data_waitrequest_o <= 1'b0;
          end else begin
            cnt <= cnt - 6'h1;
          end
        end
        default: begin
          state <= ufpc_pkg::UFPC_IDLE;
          busy <= ufpc_pkg::BUSY_IDLE;
          data_waitrequest_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Flash array
  // ----------------------------------------
  // Programming only clears bits, like real cells; unerased bits stay low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ufpc_pkg::WORDS; i++) begin
        user_flash_array[i] <= ufpc_pkg::ERASED_WORD;
      end
    end else if (prog_done) begin
      user_flash_array[prog_addr[5:0]] <= user_flash_array[prog_addr[5:0]] & prog_data;
    end
  end

  // ----------------------------------------
  // Data read path
  // ----------------------------------------
  // Single word, answer one cycle after the command is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_readdatavalid_o <= 1'b0;
      data_readdata_o <= 32'h0;
      rsucc <= 1'b0;
    end else begin
      data_readdatavalid_o <= rd_take;
      if (rd_take) begin
        data_readdata_o <= rd_word;
        rsucc <= legal;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  localparam int A_DONE = ufpc_pkg::PROG_CYCLES + 1;

  property p_busy_prog;
    @(posedge clk_i) disable iff (rst_i) (state == ufpc_pkg::UFPC_PROG) |-> (busy == ufpc_pkg::BUSY_PROG);
  endproperty
  a_busy_prog: assert property (p_busy_prog) else $error("busy code wrong in program");

  property p_idle_code;
    @(posedge clk_i) disable iff (rst_i) (state == ufpc_pkg::UFPC_IDLE) |-> (busy == ufpc_pkg::BUSY_IDLE);
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("busy code not zero in idle");

  property p_good_done;
    @(posedge clk_i) disable iff (rst_i) good_take |-> ##A_DONE (wsucc && busy == ufpc_pkg::BUSY_IDLE);
  endproperty
  a_good_done: assert property (p_good_done) else $error("program did not finish on time");

  property p_bad_clear;
    @(posedge clk_i) disable iff (rst_i) bad_take |=> (!wsucc && busy == ufpc_pkg::BUSY_IDLE);
  endproperty
  a_bad_clear: assert property (p_bad_clear) else $error("rejected program left success set");

  property p_wait_hold;
    @(posedge clk_i) disable iff (rst_i) good_take |=> data_waitrequest_o [*8];
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("waitrequest dropped during program");

  property p_wait_busy;
    @(posedge clk_i) disable iff (rst_i) data_waitrequest_o == (busy == ufpc_pkg::BUSY_PROG);
  endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("waitrequest and busy disagree");

  property p_ctrl_store;
    @(posedge clk_i) disable iff (rst_i)
      (csr_write_i && csr_address_i == ufpc_pkg::CSR_CONTROL) |=> (flash_control == $past(csr_writedata_i));
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("control write not stored");

  property p_ctrl_read;
    @(posedge clk_i) disable iff (rst_i)
      (csr_read_i && csr_address_i == ufpc_pkg::CSR_STATUS) |=> (csr_readdata_o == $past(status_word));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("status read value wrong");

  property p_one_word;
    @(posedge clk_i) disable iff (rst_i) good_take |=> !good_take [*8];
  endproperty
  a_one_word: assert property (p_one_word) else $error("second word taken during program");

  property p_rd_valid;
    @(posedge clk_i) disable iff (rst_i) rd_take |=> data_readdatavalid_o;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read answer missing");
endmodule

// >>> verification/ufpc_master.sv
// Bus master model for the flash controller's control and data slaves.
// Assumes the bench calls its tasks at falling clock edges.
`timescale 1ns/10ps
module ufpc_master (
  // Clock
  input wire logic clk_i,
  // Control slave side
  output logic csr_address_o,
  output logic csr_read_o,
  output logic csr_write_o,
  output logic [31:0] csr_writedata_o,
  input wire logic [31:0] csr_readdata_i,
  // Data slave side
  output logic [6:0] data_address_o,
  output logic data_read_o,
  output logic data_write_o,
  output logic [31:0] data_writedata_o,
  output logic [7:0] data_burstcount_o,
  input wire logic data_waitrequest_i,
  input wire logic data_readdatavalid_i,
  input wire logic [31:0] data_readdata_i
);
  // Idle levels at time zero
  initial begin
    {csr_address_o, csr_read_o, csr_write_o, csr_writedata_o} = '0;
    {data_address_o, data_read_o, data_write_o, data_writedata_o, data_burstcount_o} = '0;
  end
  // One control access; no waitrequest, so taken at the next rising edge
  task automatic csr_acc(input logic wr, input logic adr, input logic [31:0] wd, output logic [31:0] rd);
    csr_address_o = adr;
    csr_writedata_o = wd;
    csr_write_o = wr;
    csr_read_o = !wr;
    @(negedge clk_i);
    csr_write_o = 1'b0;
    csr_read_o = 1'b0;
    csr_writedata_o = ~wd;
    @(negedge clk_i);
    rd = csr_readdata_i;
  endtask
  // One data access; held while waitrequest is high, released lines inverted
  // Limitation: no erase here, so repeated programs only clear bits
  task automatic data_acc(input logic wr, input logic [6:0] adr, input logic [31:0] wd, input logic [7:0] bc,
                          output logic [31:0] rd);
    int n;
    n = 0;
    rd = 'x;
    data_address_o = adr;
    data_writedata_o = wd;
    data_burstcount_o = bc;
    data_write_o = wr;
    data_read_o = !wr;
    while (data_waitrequest_i !== 1'b0 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    {data_write_o, data_read_o} = 2'b00;
    data_address_o = ~adr;
    data_writedata_o = ~wd;
    data_burstcount_o = ~bc;
    // Read answer may land on any of the next four falling edges
    for (int i = 0; i < 4 && !wr; i++) begin
      if (data_readdatavalid_i === 1'b1) rd = data_readdata_i;
      @(negedge clk_i);
    end
  endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the flash program controller.
// Assumes the master model drives all bus inputs; bench owns clock and reset.
`timescale 1ns/10ps
module tb_top;
  logic clk_i, rst_i, csr_address, csr_read, csr_write, data_read, data_write, wreq, rvalid;
  logic [31:0] csr_wdata, csr_rdata, data_wdata, data_rdata, ctl, rd;
  logic [6:0] data_addr;
  logic [7:0] burst;
  logic [31:0] mem [64]; // Expected array contents
  int error_cnt, n_checks, wr_cnt, rv_early;
  logic [7:0] bt [5]; // Burst counts drawn for random programs
  logic [6:0] ra; // Random program address
  // ----------------------------------------
  // Design and master
  // ----------------------------------------
  ufpc_top ufpc_top_i (.clk_i(clk_i), .rst_i(rst_i), .csr_address_i(csr_address), .csr_read_i(csr_read),
    .csr_write_i(csr_write), .csr_writedata_i(csr_wdata), .csr_readdata_o(csr_rdata),
    .data_address_i(data_addr), .data_read_i(data_read), .data_write_i(data_write), .data_writedata_i(data_wdata),
    .data_burstcount_i(burst), .data_waitrequest_o(wreq), .data_readdatavalid_o(rvalid), .data_readdata_o(data_rdata));
  ufpc_master ufpc_master_i (.clk_i(clk_i), .csr_address_o(csr_address), .csr_read_o(csr_read),
    .csr_write_o(csr_write), .csr_writedata_o(csr_wdata), .csr_readdata_i(csr_rdata),
    .data_address_o(data_addr), .data_read_o(data_read), .data_write_o(data_write), .data_writedata_o(data_wdata),
    .data_burstcount_o(burst), .data_waitrequest_i(wreq), .data_readdatavalid_i(rvalid), .data_readdata_i(data_rdata));
  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Busy cycles, and read answers given while the port should stall
  always @(negedge clk_i) begin
    if (wreq === 1'b1) wr_cnt++;
    if (rvalid === 1'b1 && wreq === 1'b1) rv_early++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Program is accepted only with burst one, legal address, sector open
  function automatic logic prog_ok(input logic [6:0] a, input logic [7:0] b, input logic [31:0] c);
    return b == ufpc_pkg::BURST_ONE && a < ufpc_pkg::ADDR_LIMIT && !c[a[5:4]] && !ufpc_pkg::SECTOR_LOCK[a[5:4]];
  endfunction
  // Unprotect, program, read back, check status, reprotect
  task automatic op(input logic [6:0] a, input logic [31:0] d, input logic [7:0] b, input logic unp);
    logic ok;
    logic [31:0] st;
    if (unp) ctl[a[5:4]] = 1'b0;
    ufpc_master_i.csr_acc(1'b1, ufpc_pkg::CSR_CONTROL, ctl, rd);
    ok = prog_ok(a, b, ctl);
    wr_cnt = 0;
    ufpc_master_i.data_acc(1'b1, a, d, b, rd);
    ufpc_master_i.csr_acc(1'b0, ufpc_pkg::CSR_STATUS, 32'h0, st);
    check(st[1:0], ok ? ufpc_pkg::BUSY_PROG : ufpc_pkg::BUSY_IDLE);
    if (ok) mem[a[5:0]] = mem[a[5:0]] & d;
    // Read issued while busy; must stall until the program ends
    ufpc_master_i.data_acc(1'b0, a, 32'h0, ufpc_pkg::BURST_ONE, rd);
    check(rd, a < ufpc_pkg::ADDR_LIMIT ? mem[a[5:0]] : ufpc_pkg::ERASED_WORD);
    check(rv_early, 0);
    check(wr_cnt, ok ? ufpc_pkg::PROG_CYCLES : 0);
    ufpc_master_i.csr_acc(1'b0, ufpc_pkg::CSR_STATUS, 32'h0, st);
    check(st, {28'h0, ok, a < ufpc_pkg::ADDR_LIMIT, ufpc_pkg::BUSY_IDLE});
    ctl[a[5:4]] = 1'b1;
    ufpc_master_i.csr_acc(1'b1, ufpc_pkg::CSR_CONTROL, ctl, rd);
    ufpc_master_i.csr_acc(1'b0, ufpc_pkg::CSR_CONTROL, 32'h0, st);
    check(st, ctl);
  endtask
  // Watchdog, well past the expected run length
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {error_cnt, n_checks, wr_cnt, rv_early} = '0;
    bt = '{8'h01, 8'h01, 8'h20, 8'h00, 8'h02};
    ctl = ufpc_pkg::CONTROL_RESET;
    foreach (mem[i]) mem[i] = ufpc_pkg::ERASED_WORD;
    rst_i = 1'b1;
    void'($urandom(75800));
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    ufpc_master_i.csr_acc(1'b0, ufpc_pkg::CSR_STATUS, 32'h0, rd);
    check(rd, 32'h0);
    ufpc_master_i.csr_acc(1'b0, ufpc_pkg::CSR_CONTROL, 32'h0, rd);
    check(rd, ufpc_pkg::CONTROL_RESET);
    op(7'h05, $urandom, 8'h01, 1'b0);
    // Status is read-only: a write there must not stick
    ufpc_master_i.csr_acc(1'b1, ufpc_pkg::CSR_STATUS, 32'hffffffff, rd);
    ufpc_master_i.csr_acc(1'b0, ufpc_pkg::CSR_STATUS, 32'h0, rd);
    check(rd, 32'h4);
    // Corners: last two words, first illegal word, burst 32, burst 0
    op(7'h3f, $urandom, 8'h01, 1'b1);
    op(7'h3e, $urandom, 8'h01, 1'b1);
    op(7'h40, $urandom, 8'h01, 1'b1);
    op(7'h10, $urandom, 8'h20, 1'b1);
    op(7'h20, $urandom, 8'h00, 1'b1);
    ctl = $urandom;
    ufpc_master_i.csr_acc(1'b1, ufpc_pkg::CSR_CONTROL, ctl, rd);
    repeat (20) begin
      // No erase path, so a word is only programmed while still erased
      ra = 7'($urandom);
      while (ra < ufpc_pkg::ADDR_LIMIT && mem[ra[5:0]] !== ufpc_pkg::ERASED_WORD) begin
        ra = 7'($urandom);
      end
      op(ra, $urandom, bt[$urandom % 5], $urandom % 4 != 0);
    end
    complete_run();
  end
endmodule
